/* File: bench/nwg_guard_top_tb.sv */
// self-checking bench for the write-guard and power-mode block
// assumes the serial master model drives the link; other inputs change on clk_sys falling edge
`default_nettype none

module nwg_guard_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import nwg_pkg::*;

	logic        clk_sys, rst, sck, cs_n, mosi, wr_guard_n, deep_exit_req, array_busy;
	logic        aw_go, pw_go, cw_go, st_go;
	logic [7:0]  nv_status_in, status_byte;
	logic [15:0] guarded_addr;
	nwg_pmode_t  power_mode;
	int          err_total = 0;
	int          cmp_count = 0;
	int          n_aw = 0;
	int          n_pw = 0;
	int          n_cw = 0;
	int          n_st = 0;

	nwg_guard_top i_dut (
		.clk_sys(clk_sys), .rst(rst), .sck(sck), .cs_n(cs_n), .mosi(mosi),
		.wr_guard_n(wr_guard_n), .deep_exit_req(deep_exit_req), .array_busy(array_busy),
		.nv_status_in(nv_status_in), .status_byte(status_byte), .power_mode(power_mode),
		.guarded_addr(guarded_addr), .array_write_go(aw_go), .page_wipe_go(pw_go),
		.chip_wipe_go(cw_go), .nv_store_go(st_go)
	);

	nwg_spi_master i_master (.sck(sck), .cs_n(cs_n), .mosi(mosi));

	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	// pulses are counted so a missing or doubled request shows as a count difference
	always @(posedge clk_sys) begin
		n_aw <= n_aw + int'(aw_go);
		n_pw <= n_pw + int'(pw_go);
		n_cw <= n_cw + int'(cw_go);
		n_st <= n_st + int'(st_go);
	end

	////////////////////////////////////////////////////////////////////////////
	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge clk_sys);
	endtask

	task automatic cmd(input logic [31:0] v, input int n);
		cyc(1);
		i_master.frame(v, n);
		cyc(8);
	endtask

	task automatic wr_status(input logic [7:0] v);
		cmd(32'h06, 8);
		cmd({16'h0, 8'h01, v}, 16);
	endtask

	task automatic wait_mode(input nwg_pmode_t m);
		int k;
		for (k = 0; k < 60 && power_mode !== m; k++)
			cyc(1);
		check("power_mode", 16'(power_mode), 16'(m));
		if (k == 60)
			stop_test();
	endtask

	task automatic do_reset(input logic [7:0] nv);
		rst = 1'b1;
		nv_status_in = nv;
		cyc(20);
		check("status_in_reset", 16'(status_byte), 16'h00);
		rst = 1'b0;
		cyc(4);
	endtask

	////////////////////////////////////////////////////////////////////////////
	task automatic t_boot;
		do_reset(8'hff);
		check("status_boot", 16'(status_byte), 16'h00ec);
		do_reset(8'h00);
		wait_mode(PM_STANDBY);
		$display("test boot done");
	endtask

	task automatic t_latch;
		int s0;
		s0 = n_st;
		cmd(32'h010c, 16);
		check("status_no_latch", 16'(status_byte), 16'h00);
		cmd(32'h06, 7);
		check("latch_short", 16'(status_byte), 16'h00);
		cmd(32'h06, 8);
		check("latch_set", 16'(status_byte), 16'h02);
		cmd(32'h010c, 15);
		cmd(32'h020000, 24);
		check("bad_counts", 16'(status_byte), 16'h02);
		check("store_none", 16'(n_st - s0), 16'h0);
		cmd(32'h010c, 16);
		check("status_wr", 16'(status_byte), 16'h0e);
		check("store_one", 16'(n_st - s0), 16'h1);
		cmd(32'h04, 8);
		check("disarm", 16'(status_byte), 16'h0c);
		wr_status(8'h00);
		cmd(32'h04, 8);
		$display("test latch done");
	endtask

	task automatic t_guard;
		logic [15:0] addrs [6] = '{16'h0000, 16'h1fff, 16'h2000, 16'h2fff, 16'h3000, 16'h3fff};
		logic        prot;
		logic [15:0] a;
		int          c;
		for (int g = 0; g < 4; g++) begin
			wr_status({4'h0, 2'(g), 2'h0});
			cmd(32'h04, 8);
			for (int j = 0; j < 6; j++) begin
				a = addrs[j];
				prot = (2'(g) == GUARD_ALL) || (2'(g) == GUARD_HALF && a >= ADDR_HALF)
					|| (2'(g) == GUARD_QUARTER && a >= ADDR_QUARTER);
				c = n_aw;
				cmd(32'h06, 8);
				cmd({8'h02, a, 8'h5a}, 32);
				check("write_go", 16'(n_aw - c), 16'(!prot));
				check("latch_after_wr", 16'(status_byte[1]), 16'(prot));
				if (!prot)
					check("guarded_addr", guarded_addr, a);
				cmd(32'h04, 8);
			end
			c = n_pw;
			cmd(32'h06, 8);
			cmd(32'h423000, 24);
			check("page_wipe_go", 16'(n_pw - c), 16'(g == 0));
			c = n_cw;
			cmd(32'h06, 8);
			cmd((g % 2) ? 32'hc7 : 32'h60, 8);
			check("chip_wipe_go", 16'(n_cw - c), 16'(g == 0));
			cmd(32'h04, 8);
		end
		wr_status(8'h00);
		cmd(32'h04, 8);
		$display("test guard done");
	endtask

	task automatic t_lock;
		wr_status(8'h80);
		wr_guard_n = 1'b0;
		cmd(32'h0100, 16);
		check("locked", 16'(status_byte), 16'h82);
		wr_guard_n = 1'b1;
		cmd(32'h0100, 16);
		check("pin_high", 16'(status_byte), 16'h02);
		wr_guard_n = 1'b0;
		cmd(32'h0104, 16);
		check("lock_clear", 16'(status_byte), 16'h06);
		wr_status(8'h00);
		cmd(32'h04, 8);
		wr_guard_n = 1'b1;
		$display("test lock done");
	endtask

	task automatic t_modes;
		logic [7:0] cfg [3] = '{8'h00, 8'h40, 8'h20};
		nwg_pmode_t idle [3] = '{PM_STANDBY, PM_AUTO_SLEEP, PM_LOW_STANDBY};
		for (int i = 0; i < 3; i++) begin
			wr_status(cfg[i]);
			cmd(32'h04, 8);
			wait_mode(idle[i]);
			cyc(1);
			fork
				i_master.frame(32'h06, 8);
				begin
					cyc(30);
					check("mode_selected", 16'(power_mode), 16'(PM_ACTIVE));
				end
			join
			cyc(8);
			check("cmd_after_wake", 16'(status_byte[1]), 16'h1);
			cmd(32'hb9, 8);
			wait_mode(PM_SLEEP);
			check("sleep_clears", 16'(status_byte[1]), 16'h0);
			cmd(32'h06, 8);
			check("sleep_ignores", 16'(status_byte[1]), 16'h0);
			check("sleep_stays", 16'(power_mode), 16'(PM_SLEEP));
			cmd(32'hab, 8);
			wait_mode(idle[i]);
			cmd(32'h06, 8);
			check("armed_after", 16'(status_byte[1]), 16'h1);
			cmd(32'h04, 8);
		end
		wr_status(8'h00);
		cmd(32'h04, 8);
		$display("test modes done");
	endtask

	task automatic t_deep;
		cmd(32'h06, 8);
		cmd(32'h79, 8);
		wait_mode(PM_DEEP);
		cmd(32'hab, 8);
		cmd(32'h05, 8);
		cmd(32'h04, 8);
		check("deep_ignores", 16'(status_byte[1]), 16'h1);
		check("deep_stays", 16'(power_mode), 16'(PM_DEEP));
		deep_exit_req = 1'b1;
		cyc(8);
		deep_exit_req = 1'b0;
		wait_mode(PM_STANDBY);
		cmd(32'h04, 8);
		$display("test deep done");
	endtask

	task automatic t_busy;
		array_busy = 1'b1;
		cyc(3);
		check("busy_bit", 16'(status_byte[0]), 16'h1);
		check("busy_not_idle", 16'(power_mode), 16'(PM_ACTIVE));
		array_busy = 1'b0;
		wait_mode(PM_STANDBY);
		$display("test busy done");
	endtask

	////////////////////////////////////////////////////////////////////////////
	initial begin
		rst = 1'b1;
		wr_guard_n = 1'b1;
		deep_exit_req = 1'b0;
		array_busy = 1'b0;
		nv_status_in = 8'h00;
		t_boot();
		t_latch();
		t_guard();
		t_lock();
		t_modes();
		t_deep();
		t_busy();
		stop_test();
	end

	// hang guard: well beyond the longest expected run
	initial begin
		#900us;
		err_total++;
		stop_test();
	end
endmodule

`default_nettype wire

/* File: bench/nwg_spi_master.sv */
// serial master model for the write-guard block: mode 0, link clock stopped between frames
// assumes the bench calls frame by hierarchical name, one frame at a time
`default_nettype none

module nwg_spi_master (
	// link
	output var logic sck,
	output var logic cs_n,
	output var logic mosi
);
	timeunit 1ns;
	timeprecision 1ps;

	// fixed slow link rate, never changed while any idle mode bit is set
	localparam time HALF = 40ns;

	initial begin
		sck  = 1'b0;
		cs_n = 1'b1;
		mosi = 1'b1;
	end

	////////////////////////////////////////////////////////////////////////////
	// sends the low n bits of val msb first, exactly n clocks
	task automatic frame(input logic [31:0] val, input int n);
		#3ns cs_n = 1'b0;
		#HALF;
		for (int i = n - 1; i >= 0; i--) begin
			mosi = val[i];
			#HALF sck = 1'b1;
			#HALF sck = 1'b0;
		end
		// line released: show the inverse so a stale bit is never mistaken for data
		mosi = ~mosi;
		#HALF cs_n = 1'b1;
		// select stays high well beyond the synchroniser delay
		#(2 * HALF);
	endtask
endmodule

`default_nettype wire

/* File: rtl/nwg_guard_top.sv */
// write guard and idle power modes of a serial non-volatile memory
// assumes the master frames commands with chip select and stops the link clock between frames
//
// Function
// R1 - write-type commands act only with exactly the required clock count before select rises; array write here takes any whole byte count from 32 up
// R2 - status writes refused while guard pin low and lock bit set
// R3 - program, erase and status writes need the write latch set first
// R4 - guard bits 00 none, 01 3000-3fff, 10 2000-3fff, 11 everything protected
// R5 - idle with no write running means standby unless another idle mode chosen
// R6 - sleep command enters power down; only wake is then obeyed
// R7 - deep sleep command enters ultra-deep power down; every command ignored
// R8 - ultra-deep power down left only through the dedicated exit signal
// R9 - auto-sleep bit set: idle goes to power down instead of standby
// R10 - auto-sleep power down ends when select falls; next command handled normally
// R11 - master sets auto-sleep only at slow clock, clears it before changing clock
// R12 - sleep command under auto-sleep gives true power down; select fall does not wake
// R13 - low-standby bit set: idle goes to low-power standby
// R14 - low-power standby ends when select falls; next command handled normally
// R15 - master enables low-standby only at slow clock, clears before changing clock
// R16 - sleep command under low-standby gives power down; only wake obeyed
// R17 - status byte: lock, auto, low-standby, zero, guard1, guard0, latch, busy
// R18 - sleep b9, deep sleep 79, wake ab, all without address or data
// R19 - latch cleared by power-up, disarm, array write, wipes, sleep; not by bad frames
// R20 - ultra-deep exit is one external wake request input
// R21 - lock, guard, auto, low-standby survive power cycles; latch and busy reset
`default_nettype none

module nwg_guard_top (
	// system clock and reset
	input  wire logic               clk_sys,
	input  wire logic               rst,
	// serial link
	input  wire logic               sck,
	input  wire logic               cs_n,
	input  wire logic               mosi,
	// pins and array engine
	input  wire logic               wr_guard_n,
	input  wire logic               deep_exit_req,
	input  wire logic               array_busy,
	input  wire logic [7:0]         nv_status_in,
	// status and mode
	output var  logic [7:0]         status_byte,
	output var  nwg_pkg::nwg_pmode_t power_mode,
	output var  logic [15:0]        guarded_addr,
	// array engine requests, one-cycle pulses
	output var  logic               array_write_go,
	output var  logic               page_wipe_go,
	output var  logic               chip_wipe_go,
	output var  logic               nv_store_go
);
	import nwg_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// link domain: shift in opcode, address and first data byte

	typedef struct packed {
		logic [15:0] bit_cnt;
		logic [7:0]  shift;
		logic [7:0]  opcode;
		logic [15:0] addr;
		logic [7:0]  data;
	} nwg_link_t;

	nwg_link_t lk_reg;
	nwg_link_t lk_next;
	logic      fresh_reg;
	logic      frame_clr;

	// words are only read by the sys side after select rises, when sck is still
	assign frame_clr = rst | cs_n;

	always_ff @(posedge sck or posedge frame_clr) begin
		if (frame_clr) begin
			fresh_reg <= 1'b1;
		end else begin
			fresh_reg <= 1'b0;
		end
	end

	always_comb begin
		lk_next         = lk_reg;
		lk_next.bit_cnt = fresh_reg ? 16'h0001 : lk_reg.bit_cnt + 16'h0001;
		lk_next.shift   = {lk_reg.shift[6:0], mosi};
		if (lk_next.bit_cnt == BITS_OPCODE) begin
			lk_next.opcode = lk_next.shift;
		end
		if (lk_next.bit_cnt == BITS_ADDR_HI) begin
			lk_next.addr[15:8] = lk_next.shift;
			lk_next.data       = lk_next.shift;
		end
		if (lk_next.bit_cnt == BITS_PAGE_WIPE) begin
			lk_next.addr[7:0] = lk_next.shift;
		end
	end

	always_ff @(posedge sck or posedge rst) begin
		if (rst) begin
			lk_reg <= '0;
		end else begin
			lk_reg <= lk_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// pin synchronisers

	logic cs_hi_s;
	logic guard_pin_s;
	logic exit_s;

	nwg_sync3 #(.RESET_VAL(1'b1)) u_sync_cs (
		.clk_sys   (clk_sys),
		.rst       (rst),
		.pin_in    (cs_n),
		.level_out (cs_hi_s)
	);

	nwg_sync3 #(.RESET_VAL(1'b1)) u_sync_guard (
		.clk_sys   (clk_sys),
		.rst       (rst),
		.pin_in    (wr_guard_n),
		.level_out (guard_pin_s)
	);

	nwg_sync3 #(.RESET_VAL(1'b0)) u_sync_exit (
		.clk_sys   (clk_sys),
		.rst       (rst),
		.pin_in    (deep_exit_req),
		.level_out (exit_s)
	);

	////////////////////////////////////////////////////////////////////////////////
	// sys domain state

	typedef struct packed {
		nwg_pmode_t  mode;
		logic        boot;
		logic        cs_prev;
		logic        exit_prev;
		logic        lock;
		logic        auto_sleep;
		logic        low_stby;
		logic [1:0]  guard;
		logic        latch;
		logic        busy;
		logic [7:0]  status;
		logic [15:0] addr;
		logic        aw_go;
		logic        pw_go;
		logic        cw_go;
		logic        nv_go;
	} nwg_sys_t;

	nwg_sys_t st_reg;
	nwg_sys_t st_next;

	logic        frame_end;
	logic        exit_rise;
	logic [15:0] bits;
	logic        whole_bytes;
	logic [15:0] addr_m;
	logic        prot_hit;
	logic        sr_locked;
	logic        idle;

	assign frame_end   = cs_hi_s & ~st_reg.cs_prev & ~st_reg.boot;
	assign exit_rise   = exit_s & ~st_reg.exit_prev;
	assign bits        = lk_reg.bit_cnt;
	assign whole_bytes = (bits[2:0] == 3'h0);
	assign addr_m      = lk_reg.addr & ADDR_TOP;
	assign sr_locked   = st_reg.lock & ~guard_pin_s;                        // [R2]
	assign idle        = cs_hi_s & ~st_reg.busy & ~array_busy;

	always_comb begin
		unique case (st_reg.guard)                                          // [R4]
			GUARD_NONE:    prot_hit = 1'b0;
			GUARD_QUARTER: prot_hit = (addr_m >= ADDR_QUARTER);
			GUARD_HALF:    prot_hit = (addr_m >= ADDR_HALF);
			GUARD_ALL:     prot_hit = 1'b1;
		endcase
	end

	always_comb begin
		st_next           = st_reg;
		st_next.cs_prev   = cs_hi_s;
		st_next.exit_prev = exit_s;
		st_next.aw_go     = 1'b0;
		st_next.pw_go     = 1'b0;
		st_next.cw_go     = 1'b0;
		st_next.nv_go     = 1'b0;
		st_next.busy      = array_busy;

		// persistent bits are fetched once, after reset release
		if (st_reg.boot) begin                                              // [R21]
			st_next.boot       = 1'b0;
			st_next.lock       = nv_status_in[SR_LOCK];
			st_next.auto_sleep = nv_status_in[SR_AUTO];
			st_next.low_stby   = nv_status_in[SR_LOWSTBY];
			st_next.guard      = nv_status_in[SR_GUARD1:SR_GUARD0];
		end

		// idle mode selection; sleep and deep states hold until their own exit
		if (st_reg.mode != PM_SLEEP && st_reg.mode != PM_DEEP) begin
			if (!idle) begin
				st_next.mode = PM_ACTIVE;                                   // [R10] [R14]
			end else if (st_reg.auto_sleep) begin
				st_next.mode = PM_AUTO_SLEEP;                               // [R9]
			end else if (st_reg.low_stby) begin
				st_next.mode = PM_LOW_STANDBY;                              // [R13]
			end else begin
				st_next.mode = PM_STANDBY;                                  // [R5]
			end
		end

		if (st_reg.mode == PM_DEEP && exit_rise) begin
			st_next.mode = PM_STANDBY;                                      // [R8] [R20]
		end

		if (frame_end) begin
			if (st_reg.mode == PM_DEEP) begin
				st_next.mode = PM_DEEP;                                     // [R7]
			end else if (st_reg.mode == PM_SLEEP) begin
				if (lk_reg.opcode == OP_WAKE && bits == BITS_OPCODE) begin  // [R6] [R18]
					st_next.mode = PM_STANDBY;
				end
			end else if (!(st_reg.busy || array_busy)) begin
				// exact clock counts gate every command that changes state except array write, which takes any whole byte count from BITS_WRITE_MIN up
				unique case (lk_reg.opcode)                                 // [R1]
					OP_WRITE_ARM: begin
						if (bits == BITS_OPCODE) begin
							st_next.latch = 1'b1;
						end
					end
					OP_WRITE_DISARM: begin
						if (bits == BITS_OPCODE) begin
							st_next.latch = 1'b0;                           // [R19]
						end
					end
					OP_WRITE_STATUS: begin
						if (bits == BITS_STATUS_WR && st_reg.latch && !sr_locked) begin // [R2] [R3]
							st_next.lock       = lk_reg.data[SR_LOCK];
							st_next.auto_sleep = lk_reg.data[SR_AUTO];
							st_next.low_stby   = lk_reg.data[SR_LOWSTBY];
							st_next.guard      = lk_reg.data[SR_GUARD1:SR_GUARD0];
							st_next.nv_go      = 1'b1;                      // [R21]
						end
					end
					OP_ARRAY_WRITE: begin
						if (bits >= BITS_WRITE_MIN && whole_bytes && st_reg.latch && !prot_hit) begin
							st_next.aw_go = 1'b1;                           // [R3] [R4]
							st_next.latch = 1'b0;                           // [R19]
							st_next.busy  = 1'b1;
							st_next.addr  = lk_reg.addr;
						end
					end
					OP_PAGE_WIPE: begin
						if (bits == BITS_PAGE_WIPE && st_reg.latch && !prot_hit) begin
							st_next.pw_go = 1'b1;                           // [R3] [R4]
							st_next.latch = 1'b0;                           // [R19]
							st_next.busy  = 1'b1;
							st_next.addr  = lk_reg.addr;
						end
					end
					OP_CHIP_WIPE, OP_CHIP_WIPE_ALT: begin
						// any guarded region blocks the whole-array wipe
						if (bits == BITS_OPCODE && st_reg.latch && st_reg.guard == GUARD_NONE) begin
							st_next.cw_go = 1'b1;                           // [R3] [R4]
							st_next.latch = 1'b0;                           // [R19]
							st_next.busy  = 1'b1;
						end
					end
					OP_SLEEP: begin
						if (bits == BITS_OPCODE) begin
							st_next.mode  = PM_SLEEP;                       // [R6] [R12] [R16]
							st_next.latch = 1'b0;                           // [R19]
						end
					end
					OP_DEEP_SLEEP: begin
						if (bits == BITS_OPCODE) begin
							st_next.mode = PM_DEEP;                         // [R7]
						end
					end
					default: begin
					end
				endcase
			end
		end

		st_next.status = {st_next.lock, st_next.auto_sleep, st_next.low_stby, 1'b0,
			st_next.guard, st_next.latch, st_next.busy};                    // [R17]
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			st_reg            <= '0;
			st_reg.mode       <= PM_STANDBY;
			st_reg.boot       <= 1'b1;
			st_reg.cs_prev    <= 1'b1;
			st_reg.status     <= SR_RESET;
		end else begin
			st_reg <= st_next;
		end
	end

	assign status_byte    = st_reg.status;
	assign power_mode     = st_reg.mode;
	assign guarded_addr   = st_reg.addr;
	assign array_write_go = st_reg.aw_go;
	assign page_wipe_go   = st_reg.pw_go;
	assign chip_wipe_go   = st_reg.cw_go;
	assign nv_store_go    = st_reg.nv_go;

	////////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	logic any_go;
	assign any_go = array_write_go | page_wipe_go | chip_wipe_go | nv_store_go;

	sequence seq_frame(logic [7:0] op);
		frame_end && lk_reg.opcode == op;
	endsequence

	sequence seq_no_action;
		!any_go && !(st_next.latch && !st_reg.latch);
	endsequence

	AST_BAD_LENGTH: assert property (seq_frame(OP_WRITE_ARM) ##0 (bits != BITS_OPCODE)
		|=> !status_byte[SR_LATCH] || $past(status_byte[SR_LATCH])) // [R1]
		else $error("arm with wrong clock count set the latch");

	AST_STATUS_LOCKED: assert property (seq_frame(OP_WRITE_STATUS) ##0 sr_locked
		|=> $stable(status_byte[7:5]) && $stable(status_byte[3:2]) && !nv_store_go) // [R2]
		else $error("status write accepted while locked");

	AST_LATCH_NEEDED: assert property (frame_end && !st_reg.latch
		|=> !array_write_go && !page_wipe_go && !chip_wipe_go && !nv_store_go) // [R3]
		else $error("write action without latch");

	AST_REGION: assert property ((array_write_go || page_wipe_go) |-> !$past(prot_hit)) // [R4]
		else $error("write issued into guarded region");

	AST_IDLE_STANDBY: assert property (power_mode == PM_ACTIVE && idle && !frame_end
		&& !st_reg.auto_sleep && !st_reg.low_stby |=> power_mode == PM_STANDBY) // [R5]
		else $error("idle did not reach standby");

	AST_SLEEP_HOLD: assert property (power_mode == PM_SLEEP && frame_end
		&& lk_reg.opcode != OP_WAKE |=> power_mode == PM_SLEEP ##0 seq_no_action) // [R6]
		else $error("sleep state obeyed a command other than wake");

	AST_DEEP_HOLD: assert property (power_mode == PM_DEEP && !exit_rise
		|=> power_mode == PM_DEEP && !any_go) // [R7]
		else $error("deep state left or acted without exit request");

	AST_DEEP_EXIT: assert property (power_mode == PM_DEEP && exit_rise
		|=> power_mode == PM_STANDBY) // [R8]
		else $error("exit request did not leave deep state");

	AST_AUTO_ENTER: assert property (power_mode == PM_ACTIVE && idle && !frame_end
		&& st_reg.auto_sleep |=> power_mode == PM_AUTO_SLEEP) // [R9]
		else $error("auto-sleep idle not entered");

	AST_AUTO_WAKE: assert property (power_mode == PM_AUTO_SLEEP && !cs_hi_s
		|=> power_mode == PM_ACTIVE) // [R10]
		else $error("auto-sleep did not wake on select");

	// select must stay low two cycles so a wake frame ending at once is not mistaken for a wake-up
	AST_TRUE_SLEEP: assert property (power_mode == PM_SLEEP && !frame_end && !cs_hi_s
		##1 !cs_hi_s |-> power_mode == PM_SLEEP [*2]) // [R12]
		else $error("true power down woke on select");

	AST_LOW_ENTER: assert property (power_mode == PM_ACTIVE && idle && !frame_end
		&& !st_reg.auto_sleep && st_reg.low_stby |=> power_mode == PM_LOW_STANDBY) // [R13]
		else $error("low standby not entered");

	AST_LOW_WAKE: assert property (power_mode == PM_LOW_STANDBY && !cs_hi_s
		|=> power_mode == PM_ACTIVE) // [R14]
		else $error("low standby did not wake on select");

	AST_RSVD_ZERO: assert property (status_byte[SR_RSVD] == 1'b0) // [R17]
		else $error("reserved status bit set");

	AST_LATCH_CLEAR: assert property ((array_write_go || page_wipe_go || chip_wipe_go)
		|-> !status_byte[SR_LATCH] && status_byte[SR_BUSY]) // [R19]
		else $error("latch not cleared by array action");

	AST_BOOT_LOAD: assert property ($fell(st_reg.boot) |-> (status_byte & SR_NV_MASK)
		== ($past(nv_status_in) & SR_NV_MASK) && !status_byte[SR_LATCH]) // [R21]
		else $error("persistent bits not restored after reset");

endmodule

`default_nettype wire

/* File: rtl/nwg_pkg.sv */
// shared constants and types for the serial memory write-guard and power-mode block
// assumes a single sys clock domain plus the serial link clock supplied by the master
`default_nettype none

package nwg_pkg;

	// instruction codes, one byte each, sent msb first
	localparam logic [7:0]  OP_WRITE_STATUS  = 8'h01;
	localparam logic [7:0]  OP_ARRAY_WRITE   = 8'h02;
	localparam logic [7:0]  OP_WRITE_DISARM  = 8'h04;
	localparam logic [7:0]  OP_STATUS_READ   = 8'h05;
	localparam logic [7:0]  OP_WRITE_ARM     = 8'h06;
	localparam logic [7:0]  OP_PAGE_WIPE     = 8'h42;
	localparam logic [7:0]  OP_CHIP_WIPE     = 8'h60;
	localparam logic [7:0]  OP_CHIP_WIPE_ALT = 8'hc7;
	localparam logic [7:0]  OP_SLEEP         = 8'hb9;
	localparam logic [7:0]  OP_DEEP_SLEEP    = 8'h79;
	localparam logic [7:0]  OP_WAKE          = 8'hab;

	// status byte field positions
	localparam int          SR_LOCK    = 7;
	localparam int          SR_AUTO    = 6;
	localparam int          SR_LOWSTBY = 5;
	localparam int          SR_RSVD    = 4;
	localparam int          SR_GUARD1  = 3;
	localparam int          SR_GUARD0  = 2;
	localparam int          SR_LATCH   = 1;
	localparam int          SR_BUSY    = 0;
	localparam logic [7:0]  SR_NV_MASK = 8'hec;
	localparam logic [7:0]  SR_RESET   = 8'h00;

	// frame lengths and capture points in serial clocks; array write needs at least BITS_WRITE_MIN
	localparam logic [15:0] BITS_OPCODE    = 16'h0008;
	localparam logic [15:0] BITS_STATUS_WR = 16'h0010;
	localparam logic [15:0] BITS_ADDR_HI   = 16'h0010;
	localparam logic [15:0] BITS_PAGE_WIPE = 16'h0018;
	localparam logic [15:0] BITS_WRITE_MIN = 16'h0020;

	// region guard codes and protected address bounds
	localparam logic [1:0]  GUARD_NONE    = 2'h0;
	localparam logic [1:0]  GUARD_QUARTER = 2'h1;
	localparam logic [1:0]  GUARD_HALF    = 2'h2;
	localparam logic [1:0]  GUARD_ALL     = 2'h3;
	localparam logic [15:0] ADDR_QUARTER  = 16'h3000;
	localparam logic [15:0] ADDR_HALF     = 16'h2000;
	localparam logic [15:0] ADDR_TOP      = 16'h3fff;

	typedef enum logic [2:0] {
		PM_ACTIVE,
		PM_STANDBY,
		PM_AUTO_SLEEP,
		PM_LOW_STANDBY,
		PM_SLEEP,
		PM_DEEP
	} nwg_pmode_t;

	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic level;
	} nwg_sync_t;

endpackage

`default_nettype wire

/* File: rtl/nwg_sync3.sv */
// three-stage synchroniser with agreement filter for one pin level
// assumes the input is asynchronous to clk_sys; output is a flop
`default_nettype none

module nwg_sync3 #(
	parameter logic RESET_VAL = 1'b0
) (
	// clock and reset
	input  wire logic clk_sys,
	input  wire logic rst,
	// pin side
	input  wire logic pin_in,
	// filtered level
	output var  logic level_out
);
	import nwg_pkg::*;

	nwg_sync_t st_reg;
	nwg_sync_t st_next;

	always_comb begin
		st_next    = st_reg;
		st_next.s1 = pin_in;
		st_next.s2 = st_reg.s1;
		st_next.s3 = st_reg.s2;
		// s1 feeds s2 only; a change counts once two later stages agree
		if (st_reg.s2 == st_reg.s3) begin
			st_next.level = st_reg.s3;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			st_reg <= '{s1: RESET_VAL, s2: RESET_VAL, s3: RESET_VAL, level: RESET_VAL};
		end else begin
			st_reg <= st_next;
		end
	end

	assign level_out = st_reg.level;

endmodule

`default_nettype wire
